//--- verilog/power_state_comms_control.sv
// power state machine and serial-bus target with comms enable and comms reset
`timescale 1ns/100ps
module power_state_comms_control
	import power_comms_pkg::*;
#(
	parameter int REG_DEPTH = 16
)(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       comms_reset_pin,
	input  wire logic       comms_enable_pin,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       int_request,
	output logic            int_out,
	output logic            int_oe,
	input  wire logic       spare_drive_low,
	output logic            spare_io_out,
	output logic            spare_io_oe,
	output pwr_state_t      power_state,
	output logic            light_emitter,
	output logic            start_refused
);
	localparam int AW = $clog2(REG_DEPTH);
	if (REG_DEPTH < 2 || REG_DEPTH > 256)
	begin : g_depth_check
		$error("REG_DEPTH must lie between 2 and 256");
	end
	typedef logic [REG_DEPTH-1:0][7:0] mem_t;
	typedef struct packed {
		logic [1:0] rst_s;
		logic [1:0] dis_s;
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic       scl_d;
		logic       sda_d;
		bus_phase_t phase;
		bus_phase_t after;
		logic       ack_on;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [15:0] idx;
		logic       sda_oe;
		mem_t       mem;
		pwr_state_t pstate;
		logic       via_pin;
		logic       light;
		logic       refused;
		logic       int_oe;
		logic       gp_oe;
	} state_t;
	state_t q;
	state_t d;
	logic   scl_rise;
	logic   scl_fall;
	logic   bus_start;
	logic   bus_stop;
	logic   comms_off;
	logic   wr_hit;
	logic   cmd_hit;
	logic [7:0] wr_byte;
	function automatic logic in_user(input logic [15:0] idx);
		in_user = (idx >= REG_BASE) && (idx < REG_BASE + 16'(REG_DEPTH));
	endfunction : in_user
	function automatic logic [AW-1:0] user_off(input logic [15:0] idx);
		logic [15:0] off;
		off = idx - REG_BASE;
		user_off = off[AW-1:0];
	endfunction : user_off
	function automatic logic [7:0] read_byte(input logic [15:0] idx, input mem_t mem,
		input pwr_state_t ps);
		if (idx == STAT_IDX)
			read_byte = {6'h00, ps};
		else if (in_user(idx))
			read_byte = mem[user_off(idx)];
		else
			read_byte = READ_NONE;
	endfunction : read_byte
	// only second and third sync stages are looked at
	assign scl_rise  = q.scl_s[1] & ~q.scl_d;
	assign scl_fall  = ~q.scl_s[1] & q.scl_d;
	assign bus_start = q.scl_s[1] & q.scl_d & q.sda_d & ~q.sda_s[1];
	assign bus_stop  = q.scl_s[1] & q.scl_d & ~q.sda_d & q.sda_s[1];
	assign comms_off = q.rst_s[1] | q.dis_s[1];
	always_comb
	begin
		logic [7:0] byte_in;
		logic [7:0] rb;
		byte_in = {q.shift[6:0], q.sda_s[1]};
		rb      = read_byte(q.idx, q.mem, q.pstate);
		d       = q;
		wr_hit  = 1'b0;
		cmd_hit = 1'b0;
		wr_byte = byte_in;
		d.rst_s = {q.rst_s[0], comms_reset_pin};
		// pin stored inverted so the reset value means enabled
		d.dis_s = {q.dis_s[0], ~comms_enable_pin};
		d.scl_s = {q.scl_s[0], scl_in};
		d.sda_s = {q.sda_s[0], sda_in};
		d.scl_d = q.scl_s[1];
		d.sda_d = q.sda_s[1];
		d.refused = 1'b0;
		if (comms_off)
		begin
			d.phase  = ph_idle;
			d.sda_oe = 1'b0;
			d.ack_on = 1'b0;
		end
		else if (bus_start)
		begin
			d.phase  = ph_addr;
			d.cnt    = '0;
			d.sda_oe = 1'b0;
			d.ack_on = 1'b0;
		end
		else if (bus_stop)
		begin
			d.phase  = ph_idle;
			d.sda_oe = 1'b0;
			d.ack_on = 1'b0;
		end
		else if (scl_rise)
		begin
			case (q.phase)
				ph_addr, ph_idxh, ph_idxl, ph_wdat:
				begin
					d.shift = byte_in;
					d.cnt   = q.cnt + CNT_ONE;
					if (q.cnt[2:0] == BYTE_LAST)
					begin
						d.cnt    = '0;
						d.phase  = ph_ack;
						d.ack_on = 1'b0;
						case (q.phase)
							ph_addr:
							begin
								if (byte_in[7:1] == DEV_ADDR_BYTE[7:1])
									d.after = byte_in[0] ? ph_rdat : ph_idxh;
								else
									d.phase = ph_idle;
							end
							ph_idxh:
							begin
								d.idx[15:8] = byte_in;
								d.after     = ph_idxl;
							end
							ph_idxl:
							begin
								d.idx[7:0] = byte_in;
								d.after    = ph_wdat;
							end
							default:
							begin
								wr_hit  = 1'b1;
								d.idx   = q.idx + IDX_STEP;
								d.after = ph_wdat;
							end
						endcase
					end
				end
				ph_mack:
				begin
					// host nack ends the read
					if (q.sda_s[1])
						d.phase = ph_idle;
					else
					begin
						d.shift = rb;
						d.cnt   = '0;
						d.phase = ph_rdat;
					end
				end
				default: ;
			endcase
		end
		else if (scl_fall)
		begin
			case (q.phase)
				ph_ack:
				begin
					if (!q.ack_on)
					begin
						d.sda_oe = 1'b1;
						d.ack_on = 1'b1;
					end
					else
					begin
						d.ack_on = 1'b0;
						d.sda_oe = 1'b0;
						d.phase  = q.after;
						d.cnt    = '0;
						if (q.after == ph_rdat)
						begin
							d.sda_oe = ~rb[7];
							d.shift  = {rb[6:0], 1'b0};
							d.cnt    = CNT_ONE;
						end
					end
				end
				ph_rdat:
				begin
					if (q.cnt < BITS_SENT)
					begin
						d.sda_oe = ~q.shift[7];
						d.shift  = {q.shift[6:0], 1'b0};
						d.cnt    = q.cnt + CNT_ONE;
					end
					else
					begin
						d.sda_oe = 1'b0;
						d.phase  = ph_mack;
						d.idx    = q.idx + IDX_STEP;
					end
				end
				default: ;
			endcase
		end
		cmd_hit = wr_hit && (q.idx == CMD_IDX);
		// array writes come only from the bus; no power-state change clears it, only rst_n does
		if (wr_hit && in_user(q.idx))
			d.mem[user_off(q.idx)] = wr_byte;
		if (cmd_hit && wr_byte == CMD_START && q.pstate != high_power_idle_state)
			d.refused = 1'b1;
		case (q.pstate)
			high_power_idle_state:
			begin
				if (q.dis_s[1])
				begin
					d.pstate  = low_power_idle_state;
					d.via_pin = 1'b1;
				end
				else if (cmd_hit && wr_byte == CMD_START)
					d.pstate = ranging_state;
				else if (cmd_hit && wr_byte == CMD_LOW_POWER)
				begin
					d.pstate  = low_power_idle_state;
					d.via_pin = 1'b0;
				end
			end
			low_power_idle_state:
			begin
				// straight back, no boot sequence
				if (q.via_pin && !q.dis_s[1])
					d.pstate = high_power_idle_state;
				else if (!q.via_pin && cmd_hit && wr_byte == CMD_HIGH_POWER)
					d.pstate = high_power_idle_state;
			end
			ranging_state:
			begin
				if (cmd_hit && wr_byte == CMD_STOP)
					d.pstate = high_power_idle_state;
			end
			default:
				d.pstate = high_power_idle_state;
		endcase
		d.light  = (d.pstate == ranging_state);
		d.int_oe = int_request;
		d.gp_oe  = spare_drive_low;
	end
	// reset enters high-power idle, bus idle, pins released
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end
	assign sda_out       = 1'b0;
	assign sda_oe        = q.sda_oe;
	assign int_out       = 1'b0;
	assign int_oe        = q.int_oe;
	assign spare_io_out  = 1'b0;
	assign spare_io_oe   = q.gp_oe;
	assign power_state   = q.pstate;
	assign light_emitter = q.light;
	assign start_refused = q.refused;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_byte_in(bus_phase_t ph);
		!comms_off && !bus_start && !bus_stop && scl_rise && q.phase == ph
			&& q.cnt[2:0] == BYTE_LAST;
	endsequence
	sequence s_start_cmd;
		cmd_hit && wr_byte == CMD_START;
	endsequence
	a_comms_reset_idle: assert property (q.rst_s[1] |=> q.phase == ph_idle && !sda_oe)
		else $error("bus logic not held idle by comms reset");
	a_reset_keeps_core: assert property (q.rst_s[1] |=> $stable(q.mem))
		else $error("comms reset disturbed register contents");
	a_int_open_drain: assert property (int_out == 1'b0 && int_oe == $past(int_request))
		else $error("interrupt pin drives high or lags");
	a_spare_open_drain: assert property (spare_io_out == 1'b0
		&& spare_io_oe == $past(spare_drive_low))
		else $error("spare pin drives high or lags");
	a_comms_gated: assert property (q.dis_s[1] |=> !sda_oe ##1 !sda_oe)
		else $error("bus answered while comms disabled");
	a_lp_retains: assert property (q.pstate == low_power_idle_state && q.via_pin
		|=> $stable(q.mem))
		else $error("low-power idle lost register contents");
	a_lp_resume: assert property (q.pstate == low_power_idle_state && q.via_pin
		&& !q.dis_s[1] |=> q.pstate == high_power_idle_state)
		else $error("no direct resume to high-power idle");
	a_lp_pin_enter: assert property (q.pstate == high_power_idle_state && q.dis_s[1]
		|=> q.pstate == low_power_idle_state && q.via_pin)
		else $error("comms enable low did not enter low-power idle");
	a_start_only_hp: assert property (s_start_cmd |=>
		($past(q.pstate) == high_power_idle_state) ? (q.pstate == ranging_state && !start_refused)
		: (q.pstate == $past(q.pstate) && start_refused))
		else $error("start handled outside high-power idle");
	a_emitter_ranging: assert property (light_emitter == (power_state == ranging_state))
		else $error("emitter active outside ranging");
	a_addr_match: assert property (s_byte_in(ph_addr) |=> (q.phase == ph_ack)
		== (q.shift[7:1] == DEV_ADDR_BYTE[7:1]))
		else $error("address byte decoded wrongly");
	a_index_step: assert property (s_byte_in(ph_wdat) |=> q.idx == $past(q.idx) + IDX_STEP)
		else $error("index did not advance after data byte");
	a_stop_to_hp: assert property (q.pstate == ranging_state && cmd_hit
		&& wr_byte == CMD_STOP |=> q.pstate == high_power_idle_state && !light_emitter)
		else $error("stop did not return to high-power idle");
endmodule : power_state_comms_control

//--- pkg/power_comms_pkg.sv
// constants and types shared by the power state and comms control block
package power_comms_pkg;

	localparam logic [7:0]  DEV_ADDR_BYTE  = 8'h52;
	localparam logic [15:0] CMD_IDX        = 16'h0000;
	localparam logic [15:0] STAT_IDX       = 16'h0001;
	localparam logic [15:0] REG_BASE       = 16'h0100;
	localparam logic [15:0] IDX_STEP       = 16'h0001;
	localparam logic [7:0]  CMD_START      = 8'h01;
	localparam logic [7:0]  CMD_STOP       = 8'h02;
	localparam logic [7:0]  CMD_LOW_POWER  = 8'h03;
	localparam logic [7:0]  CMD_HIGH_POWER = 8'h04;
	localparam logic [7:0]  READ_NONE      = 8'h00;
	localparam logic [2:0]  BYTE_LAST      = 3'h7;
	localparam logic [3:0]  BITS_SENT      = 4'h8;
	localparam logic [3:0]  CNT_ONE        = 4'h1;

	typedef enum logic [1:0] {
		high_power_idle_state,
		low_power_idle_state,
		ranging_state
	} pwr_state_t;

	typedef enum logic [2:0] {
		ph_idle,
		ph_addr,
		ph_idxh,
		ph_idxl,
		ph_wdat,
		ph_rdat,
		ph_ack,
		ph_mack
	} bus_phase_t;

endpackage : power_comms_pkg

//--- sim/host_bus_model.sv
// host controller model that clocks the two-wire bus from the far side
`timescale 1ns/100ps
module host_bus_model (
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);

	// bus idles high and scl stands still between frames
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// data moves only while scl is low, sampled mid high phase
	task automatic bit_io(input logic b, output logic s);
		cyc(4);
		sda_drv <= b;
		cyc(4);
		scl <= 1'b1;
		cyc(4);
		#1 s = sda_line;
		cyc(4);
		scl <= 1'b0;
	endtask : bit_io

	// also serves as repeated start, index kept by the target
	task automatic start();
		cyc(4);
		sda_drv <= 1'b1;
		cyc(4);
		scl <= 1'b1;
		cyc(4);
		sda_drv <= 1'b0;
		cyc(4);
		scl <= 1'b0;
	endtask : start

	task automatic stop();
		cyc(4);
		sda_drv <= 1'b0;
		cyc(4);
		scl <= 1'b1;
		cyc(4);
		sda_drv <= 1'b1;
		cyc(4);
	endtask : stop

	// ack_in 1 releases the line; reads send 8'hFF so the target can drive
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_out);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack_out);
	endtask : xfer

endmodule : host_bus_model

//--- sim/power_state_comms_control_tb.sv
// self-checking bench for the power state and comms control block
`timescale 1ns/100ps
module power_state_comms_control_tb
	import power_comms_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst_n;
	logic       comms_reset_pin;
	logic       comms_enable_pin;
	logic       int_request;
	logic       spare_drive_low;
	logic       scl;
	logic       sda_drv;
	logic       sda_out;
	logic       sda_oe;
	logic       int_out;
	logic       int_oe;
	logic       spare_io_out;
	logic       spare_io_oe;
	logic       light_emitter;
	logic       start_refused;
	pwr_state_t power_state;
	logic [7:0] refused_cnt = 8'h00;
	logic [7:0] r0;
	logic [7:0] r1;
	logic [7:0] rx;
	logic       a;
	int         fail_count = 0;
	int         samples_checked = 0;
	// pull-up wins unless a party pulls low
	wire        sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

	always #5 clk = ~clk;

	// the refusal is a one-cycle pulse, so count it where it stands
	always @(posedge clk)
		if (start_refused === 1'b1)
			refused_cnt <= refused_cnt + 8'h01;

	host_bus_model i_host_bus_model (
		.clk      (clk),
		.sda_line (sda_line),
		.scl      (scl),
		.sda_drv  (sda_drv)
	);

	power_state_comms_control i_power_state_comms_control (
		.clk              (clk),
		.rst_n            (rst_n),
		.comms_reset_pin  (comms_reset_pin),
		.comms_enable_pin (comms_enable_pin),
		.scl_in           (scl),
		.sda_in           (sda_line),
		.sda_out          (sda_out),
		.sda_oe           (sda_oe),
		.int_request      (int_request),
		.int_out          (int_out),
		.int_oe           (int_oe),
		.spare_drive_low  (spare_drive_low),
		.spare_io_out     (spare_io_out),
		.spare_io_oe      (spare_io_oe),
		.power_state      (power_state),
		.light_emitter    (light_emitter),
		.start_refused    (start_refused)
	);

	task automatic close_out();
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask : chk

	task automatic st(input pwr_state_t want);
		chk({6'h00, power_state}, {6'h00, want});
	endtask : st

	task automatic pause(input int n);
		i_host_bus_model.cyc(n);
		#1;
	endtask : pause

	task automatic send(input logic [7:0] b);
		i_host_bus_model.xfer(b, 1'b1, rx, a);
		chk({7'h00, a}, 8'h00);
	endtask : send

	task automatic wr(input logic [15:0] idx, input logic [7:0] d0, input logic [7:0] d1,
		input logic two);
		i_host_bus_model.start();
		send(DEV_ADDR_BYTE);
		send(idx[15:8]);
		send(idx[7:0]);
		send(d0);
		if (two)
			send(d1);
		i_host_bus_model.stop();
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic two);
		i_host_bus_model.start();
		send(DEV_ADDR_BYTE);
		send(idx[15:8]);
		send(idx[7:0]);
		i_host_bus_model.start();
		send(DEV_ADDR_BYTE | 8'h01);
		i_host_bus_model.xfer(8'hFF, ~two, r0, a);
		if (two)
			i_host_bus_model.xfer(8'hFF, 1'b1, r1, a);
		i_host_bus_model.stop();
	endtask : rd

	task automatic probe(input logic [7:0] addr, input logic nack);
		i_host_bus_model.start();
		i_host_bus_model.xfer(addr, 1'b1, rx, a);
		chk({7'h00, a}, {7'h00, nack});
		i_host_bus_model.stop();
	endtask : probe

	task automatic cmd(input logic [7:0] c);
		wr(CMD_IDX, c, 8'h00, 1'b0);
		pause(2);
	endtask : cmd

	initial
	begin
		#500000;
		fail_count++;
		close_out();
	end

	initial
	begin
		rst_n = 1'b0;
		comms_reset_pin = 1'b0;
		comms_enable_pin = 1'b1;
		int_request = 1'b0;
		spare_drive_low = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		pause(3);
		st(high_power_idle_state);
		chk({6'h00, light_emitter, int_oe}, 8'h00);
		chk({7'h00, spare_io_oe}, 8'h00);
		@(posedge clk);
		int_request <= 1'b1;
		spare_drive_low <= 1'b1;
		pause(2);
		chk({4'h0, int_oe, int_out, spare_io_oe, spare_io_out}, 8'h0A);
		@(posedge clk);
		int_request <= 1'b0;
		spare_drive_low <= 1'b0;
		pause(2);
		chk({6'h00, int_oe, spare_io_oe}, 8'h00);
		wr(REG_BASE, 8'hA5, 8'h3C, 1'b1);
		rd(REG_BASE, 1'b1);
		chk(r0, 8'hA5);
		chk(r1, 8'h3C);
		probe(8'h54, 1'b1);
		cmd(CMD_START);
		st(ranging_state);
		chk({7'h00, light_emitter}, 8'h01);
		rd(STAT_IDX, 1'b0);
		chk(r0, 8'h02);
		cmd(CMD_START);
		chk(refused_cnt, 8'h01);
		@(posedge clk);
		i_host_bus_model.start();
		send(DEV_ADDR_BYTE);
		send(8'h01);
		comms_reset_pin <= 1'b1;
		i_host_bus_model.cyc(4);
		comms_reset_pin <= 1'b0;
		i_host_bus_model.cyc(4);
		i_host_bus_model.xfer(8'h00, 1'b1, rx, a);
		chk({7'h00, a}, 8'h01);
		i_host_bus_model.stop();
		pause(1);
		st(ranging_state);
		cmd(CMD_STOP);
		st(high_power_idle_state);
		cmd(CMD_LOW_POWER);
		st(low_power_idle_state);
		chk({7'h00, light_emitter}, 8'h00);
		cmd(CMD_START);
		chk(refused_cnt, 8'h02);
		st(low_power_idle_state);
		rd(REG_BASE, 1'b1);
		chk(r0, 8'hA5);
		chk(r1, 8'h3C);
		cmd(CMD_HIGH_POWER);
		st(high_power_idle_state);
		@(posedge clk);
		comms_enable_pin <= 1'b0;
		pause(5);
		st(low_power_idle_state);
		probe(DEV_ADDR_BYTE, 1'b1);
		comms_enable_pin <= 1'b1;
		pause(5);
		st(high_power_idle_state);
		probe(DEV_ADDR_BYTE, 1'b0);
		close_out();
	end

endmodule : power_state_comms_control_tb
